// [common/ipeb_pkg.sv]
package ipeb_pkg;

    localparam int IPEB_DATA_W    = 16;
    localparam int IPEB_ADDR_W    = 5;
    localparam int IPEB_PRIO_W    = 3;
    localparam int IPEB_SRC_COUNT = 21;
    localparam int IPEB_SRC_IDX_W = 5;
    localparam int IPEB_FLAG_REGS = 3;
    localparam int IPEB_PRIO_REGS = 8;

    // register offsets, word addresses on the plain port
    localparam logic [4:0] IPEB_OFS_FLAG_ZERO    = 5'h00;
    localparam logic [4:0] IPEB_OFS_FLAG_ONE     = 5'h01;
    localparam logic [4:0] IPEB_OFS_FLAG_FOUR    = 5'h02;
    localparam logic [4:0] IPEB_OFS_ENABLE_ZERO  = 5'h03;
    localparam logic [4:0] IPEB_OFS_ENABLE_ONE   = 5'h04;
    localparam logic [4:0] IPEB_OFS_SERIAL_ERR_EN = 5'h05;
    localparam logic [4:0] IPEB_OFS_PRIO_ZERO    = 5'h06;
    localparam logic [4:0] IPEB_OFS_PRIO_ONE     = 5'h07;
    localparam logic [4:0] IPEB_OFS_PRIO_TWO     = 5'h08;
    localparam logic [4:0] IPEB_OFS_PRIO_THREE   = 5'h09;
    localparam logic [4:0] IPEB_OFS_PRIO_FOUR    = 5'h0a;
    localparam logic [4:0] IPEB_OFS_PRIO_FIVE    = 5'h0b;
    localparam logic [4:0] IPEB_OFS_PRIO_SEVEN   = 5'h0c;
    localparam logic [4:0] IPEB_OFS_PRIO_SIXTEEN = 5'h0d;
    localparam logic [4:0] IPEB_OFS_REQ_LOW      = 5'h0e;
    localparam logic [4:0] IPEB_OFS_REQ_HIGH     = 5'h0f;
    localparam logic [4:0] IPEB_OFS_ARB_STATUS   = 5'h10;

    // implemented bits of flag and enable words (index 0, 1, 2 = zero, one, four)
    localparam logic [2:0][15:0] IPEB_FLAG_MASK = {16'h0002, 16'h20db, 16'h3fef};
    localparam logic [15:0]      IPEB_SERIAL_ERR_BIT = 16'h0002;

    // priority words, index 7 down to 0 = sixteen, seven, five, four, three, two, one, zero
    localparam logic [7:0][15:0] IPEB_PRIO_MASK  = {16'h0070, 16'h0070, 16'h7707, 16'h7077,
                                                    16'h0077, 16'h7777, 16'h7770, 16'h7777};
    localparam logic [7:0][15:0] IPEB_PRIO_RESET = {16'h0040, 16'h0040, 16'h4404, 16'h4044,
                                                    16'h0044, 16'h4444, 16'h4440, 16'h4444};
    localparam logic [2:0]       IPEB_PRIO_OFF   = 3'h0;

    // per source: bit in the flat flag/enable vector, low bit in the flat priority vector
    localparam int IPEB_SRC_FLAG_POS [IPEB_SRC_COUNT] =
        '{0, 1, 2, 3, 5, 6, 7, 8, 9, 10, 11, 12, 13, 16, 17, 19, 20, 22, 23, 29, 33};
    localparam int IPEB_SRC_PRIO_POS [IPEB_SRC_COUNT] =
        '{0, 4, 8, 12, 20, 24, 28, 32, 36, 40, 44, 48, 52, 64, 68, 76, 80, 88, 92, 100, 116};

    typedef struct packed {
        logic [2:0][15:0]              flag;
        logic [2:0][15:0]              enable;
        logic [7:0][15:0]              prio;
        logic [15:0]                   rdata;
        logic [IPEB_SRC_COUNT-1:0]     req;
        logic [IPEB_PRIO_W-1:0]        level;
        logic [IPEB_SRC_IDX_W-1:0]     winner;
        logic                          irq;
    } ipeb_state_t;

    localparam ipeb_state_t IPEB_STATE_RESET = '{
        flag:   '0,
        enable: '0,
        prio:   IPEB_PRIO_RESET,
        rdata:  '0,
        req:    '0,
        level:  '0,
        winner: '0,
        irq:    1'b0
    };

endpackage

// [common/ipeb_src_if.sv]
`timescale 1ns/10ps
interface ipeb_src_if;
    logic       flag;
    logic       en;
    logic [2:0] prio;
    logic       req;
    logic [2:0] level;

    modport gate
    (
        input  flag,
        input  en,
        input  prio,
        output req,
        output level
    );

    modport core
    (
        output flag,
        output en,
        output prio,
        input  req,
        input  level
    );
endinterface

// [src/ipeb_src_gate.sv]
`timescale 1ns/10ps
module ipeb_src_gate
    import ipeb_pkg::*;
(
    ipeb_src_if.gate src    // one source: flag, enable, priority in; request, level out
);

    // a zero code silences the source even with flag and enable set
    assign src.req   = src.flag & src.en & (src.prio != IPEB_PRIO_OFF);
    // codes 001..111 are used directly as levels 1..7
    assign src.level = src.req ? src.prio : IPEB_PRIO_OFF;

endmodule

// [src/ipeb_bank.sv]
`timescale 1ns/10ps
module ipeb_bank
    import ipeb_pkg::*;
(
    input  wire logic                      mclk,       // system clock, 40 MHz
    input  wire logic                      reset_n,    // asynchronous reset, active low
    input  wire logic                      clk_en,     // freezes all state while low
    input  wire logic [IPEB_ADDR_W-1:0]    bus_addr,   // register word address
    input  wire logic [IPEB_DATA_W-1:0]    bus_wdata,  // write data
    input  wire logic                      bus_wr,     // write strobe
    input  wire logic                      bus_rd,     // read strobe
    input  wire logic [IPEB_SRC_COUNT-1:0] src_event,  // peripheral request pulses
    output logic      [IPEB_DATA_W-1:0]    bus_rdata,  // read data, cycle after bus_rd
    output logic      [IPEB_SRC_COUNT-1:0] src_req,    // per source request to the cpu
    output logic      [IPEB_PRIO_W-1:0]    req_level,  // highest pending level
    output logic      [IPEB_SRC_IDX_W-1:0] req_source, // source holding that level
    output logic                           irq         // any request pending
);

    ipeb_state_t                       s;
    ipeb_state_t                       next_s;
    logic [47:0]                       flag_flat;
    logic [47:0]                       en_flat;
    logic [127:0]                      prio_flat;
    logic [IPEB_SRC_COUNT-1:0]         gate_req;
    logic [IPEB_SRC_COUNT-1:0][2:0]    gate_level;

    assign flag_flat = s.flag;
    assign en_flat   = s.enable;
    assign prio_flat = s.prio;

    // one gate per source; the table maps each source onto its register bits
    genvar g;
    generate
        for (g = 0; g < IPEB_SRC_COUNT; g++)
        begin : gen_src
            ipeb_src_if u_src ();

            assign u_src.flag = flag_flat[IPEB_SRC_FLAG_POS[g]];
            assign u_src.en   = en_flat[IPEB_SRC_FLAG_POS[g]];
            assign u_src.prio = prio_flat[IPEB_SRC_PRIO_POS[g] +: IPEB_PRIO_W];

            ipeb_src_gate u_gate
            (
                .src (u_src.gate)
            );

            assign gate_req[g]   = u_src.req;
            assign gate_level[g] = u_src.level;
        end
    endgenerate

    always_comb
    begin
        logic [47:0]               flag_work;
        logic [IPEB_PRIO_W-1:0]    best_level;
        logic [IPEB_SRC_IDX_W-1:0] best_src;
        flag_work  = '0;
        best_level = IPEB_PRIO_OFF;
        best_src   = '0;
        next_s     = s;

        // read data stand for one cycle only, zero otherwise
        next_s.rdata = '0;
        if (bus_rd)
        begin
            case (bus_addr)
                IPEB_OFS_FLAG_ZERO:
                begin
                    next_s.rdata = s.flag[0];
                end
                IPEB_OFS_FLAG_ONE:
                begin
                    next_s.rdata = s.flag[1];
                end
                IPEB_OFS_FLAG_FOUR:
                begin
                    next_s.rdata = s.flag[2];
                end
                IPEB_OFS_ENABLE_ZERO:
                begin
                    next_s.rdata = s.enable[0];
                end
                IPEB_OFS_ENABLE_ONE:
                begin
                    next_s.rdata = s.enable[1];
                end
                IPEB_OFS_SERIAL_ERR_EN:
                begin
                    next_s.rdata = s.enable[2];
                end
                IPEB_OFS_PRIO_ZERO:
                begin
                    next_s.rdata = s.prio[0];
                end
                IPEB_OFS_PRIO_ONE:
                begin
                    next_s.rdata = s.prio[1];
                end
                IPEB_OFS_PRIO_TWO:
                begin
                    next_s.rdata = s.prio[2];
                end
                IPEB_OFS_PRIO_THREE:
                begin
                    next_s.rdata = s.prio[3];
                end
                IPEB_OFS_PRIO_FOUR:
                begin
                    next_s.rdata = s.prio[4];
                end
                IPEB_OFS_PRIO_FIVE:
                begin
                    next_s.rdata = s.prio[5];
                end
                IPEB_OFS_PRIO_SEVEN:
                begin
                    next_s.rdata = s.prio[6];
                end
                IPEB_OFS_PRIO_SIXTEEN:
                begin
                    next_s.rdata = s.prio[7];
                end
                IPEB_OFS_REQ_LOW:
                begin
                    next_s.rdata = s.req[15:0];
                end
                IPEB_OFS_REQ_HIGH:
                begin
                    next_s.rdata = {11'h000, s.req[IPEB_SRC_COUNT-1:16]};
                end
                IPEB_OFS_ARB_STATUS:
                begin
                    next_s.rdata = {5'h00, s.level, 3'h0, s.winner};
                end
                default:
                begin
                    next_s.rdata = '0;
                end
            endcase
        end

        // writes keep only implemented bits, so the rest reads back zero
        if (bus_wr)
        begin
            case (bus_addr)
                IPEB_OFS_FLAG_ZERO:
                begin
                    next_s.flag[0] = s.flag[0] & ~bus_wdata;
                end
                IPEB_OFS_FLAG_ONE:
                begin
                    next_s.flag[1] = s.flag[1] & ~bus_wdata;
                end
                IPEB_OFS_FLAG_FOUR:
                begin
                    next_s.flag[2] = s.flag[2] & ~bus_wdata;
                end
                IPEB_OFS_ENABLE_ZERO:
                begin
                    next_s.enable[0] = bus_wdata & IPEB_FLAG_MASK[0];
                end
                IPEB_OFS_ENABLE_ONE:
                begin
                    next_s.enable[1] = bus_wdata & IPEB_FLAG_MASK[1];
                end
                IPEB_OFS_SERIAL_ERR_EN:
                begin
                    next_s.enable[2] = bus_wdata & IPEB_SERIAL_ERR_BIT;
                end
                IPEB_OFS_PRIO_ZERO:
                begin
                    next_s.prio[0] = bus_wdata & IPEB_PRIO_MASK[0];
                end
                IPEB_OFS_PRIO_ONE:
                begin
                    next_s.prio[1] = bus_wdata & IPEB_PRIO_MASK[1];
                end
                IPEB_OFS_PRIO_TWO:
                begin
                    next_s.prio[2] = bus_wdata & IPEB_PRIO_MASK[2];
                end
                IPEB_OFS_PRIO_THREE:
                begin
                    next_s.prio[3] = bus_wdata & IPEB_PRIO_MASK[3];
                end
                IPEB_OFS_PRIO_FOUR:
                begin
                    next_s.prio[4] = bus_wdata & IPEB_PRIO_MASK[4];
                end
                IPEB_OFS_PRIO_FIVE:
                begin
                    next_s.prio[5] = bus_wdata & IPEB_PRIO_MASK[5];
                end
                IPEB_OFS_PRIO_SEVEN:
                begin
                    next_s.prio[6] = bus_wdata & IPEB_PRIO_MASK[6];
                end
                IPEB_OFS_PRIO_SIXTEEN:
                begin
                    next_s.prio[7] = bus_wdata & IPEB_PRIO_MASK[7];
                end
                default:
                begin
                    // read-only and unmapped words ignore writes
                    next_s.prio = next_s.prio;
                end
            endcase
        end

        // events land after the clear so a same-cycle event is never lost
        flag_work = next_s.flag;
        for (int i = 0; i < IPEB_SRC_COUNT; i++)
        begin
            if (src_event[i])
            begin
                flag_work[IPEB_SRC_FLAG_POS[i]] = 1'b1;
            end
        end
        next_s.flag = flag_work;

        // requests follow the stored registers, so outputs trail a write by one edge
        next_s.req = gate_req;
        next_s.irq = |gate_req;

        // highest level wins; on a tie the lowest source index is kept
        for (int i = 0; i < IPEB_SRC_COUNT; i++)
        begin
            if (gate_level[i] > best_level)
            begin
                best_level = gate_level[i];
                best_src   = IPEB_SRC_IDX_W'(i);
            end
        end
        next_s.level  = best_level;
        next_s.winner = best_src;
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s <= IPEB_STATE_RESET;
        end
        else if (clk_en)
        begin
            s <= next_s;
        end
    end

    assign bus_rdata  = s.rdata;
    assign src_req    = s.req;
    assign req_level  = s.level;
    assign req_source = s.winner;
    assign irq        = s.irq;

endmodule

// [bench/ipeb_bank_properties.sv]
`timescale 1ns/10ps
module ipeb_checker
    import ipeb_pkg::*;
(
    input wire logic                      mclk,       // clock
    input wire logic                      reset_n,    // reset
    input wire logic                      clk_en,     // enable
    input wire logic [IPEB_ADDR_W-1:0]    bus_addr,   // address
    input wire logic [IPEB_DATA_W-1:0]    bus_wdata,  // write data
    input wire logic                      bus_wr,     // write
    input wire logic                      bus_rd,     // read
    input wire logic [IPEB_SRC_COUNT-1:0] src_event,  // events
    input wire logic [IPEB_DATA_W-1:0]    bus_rdata,  // read data
    input wire logic [IPEB_SRC_COUNT-1:0] src_req,    // requests
    input wire logic [IPEB_PRIO_W-1:0]    req_level,  // level
    input wire logic [IPEB_SRC_IDX_W-1:0] req_source, // winner
    input wire logic                      irq         // interrupt
);
    logic ev_any;
    assign ev_any = |src_event;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    a_irq_any_req: assert property (irq == (src_req != '0))
        else $error("irq disagrees with request vector");
    a_idle_level: assert property ((src_req == '0) |-> (req_level == '0 && req_source == '0))
        else $error("level reported with no request");
    a_active_level: assert property ((src_req != '0) |-> (req_level != '0 && src_req[req_source]))
        else $error("winner not requesting or level zero");
    a_rdata_one_cycle: assert property (($past(clk_en) && !$past(bus_rd)) |-> bus_rdata == '0)
        else $error("read data outside its cycle");
    a_unmapped_zero: assert property ((bus_rd && clk_en && bus_addr > 5'h10) |=> bus_rdata == '0)
        else $error("unmapped read not zero");
    a_serial_en_bits: assert property ((bus_rd && clk_en && bus_addr == IPEB_OFS_SERIAL_ERR_EN)
        |=> (bus_rdata & 16'hfffd) == '0)
        else $error("serial enable word has stray bits");
    a_prio_gaps: assert property ((bus_rd && clk_en && bus_addr >= IPEB_OFS_PRIO_ZERO
        && bus_addr <= IPEB_OFS_PRIO_SIXTEEN) |=> (bus_rdata & 16'h8888) == '0)
        else $error("priority word gap bit set");
    a_quiet_stable: assert property ((!bus_wr && !ev_any) |-> ##2 $stable(src_req))
        else $error("request changed without cause");
    a_rise_cause: assert property ($rose(irq) |-> ($past(ev_any, 2) || $past(bus_wr, 2)))
        else $error("irq rose without event or write");

    c_irq_rise: cover property ($rose(irq));
    c_top_level: cover property (req_level == 3'h7);
    c_unmapped: cover property (bus_rd && bus_addr > 5'h10);
endmodule

// [bench/ipeb_periph_model.sv]
`timescale 1ns/10ps
module ipeb_periph_model
    import ipeb_pkg::*;
(
    input  wire logic                      mclk,      // system clock
    input  wire logic                      fire,      // raise one pulse
    input  wire logic [IPEB_SRC_IDX_W-1:0] fire_idx,  // source to pulse
    output logic      [IPEB_SRC_COUNT-1:0] src_event  // request pulses
);
    // one-cycle strobes, like a peripheral event line
    initial src_event = '0;
    always @(posedge mclk)
        src_event <= fire ? (IPEB_SRC_COUNT'(1) << fire_idx) : '0;
endmodule

// [bench/ipeb_bank_test.sv]
`timescale 1ns/10ps
module ipeb_bank_test;
    import ipeb_pkg::*;
    logic                      mclk;
    logic                      reset_n;
    logic                      clk_en;
    logic [IPEB_ADDR_W-1:0]    bus_addr;
    logic [IPEB_DATA_W-1:0]    bus_wdata;
    logic                      bus_wr;
    logic                      bus_rd;
    logic [IPEB_SRC_COUNT-1:0] src_event;
    logic [IPEB_DATA_W-1:0]    bus_rdata;
    logic [IPEB_SRC_COUNT-1:0] src_req;
    logic [IPEB_PRIO_W-1:0]    req_level;
    logic [IPEB_SRC_IDX_W-1:0] req_source;
    logic                      irq;
    logic                      fire;
    logic [IPEB_SRC_IDX_W-1:0] fire_idx;
    logic                      rd_pending;
    logic [15:0]               exp_q [$];
    int                        failures;
    int                        comparisons;

    ipeb_bank ipeb_bank_inst (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .src_event(src_event), .bus_rdata(bus_rdata), .src_req(src_req),
        .req_level(req_level), .req_source(req_source), .irq(irq));
    ipeb_periph_model ipeb_periph_model_inst (.mclk(mclk), .fire(fire), .fire_idx(fire_idx),
        .src_event(src_event));

    always #12.5 mclk = ~mclk;

    task automatic check(input logic [15:0] seen, input logic [15:0] expected);
        comparisons++;
        if (seen !== expected)
        begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, seen, expected);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic bus_write(input logic [4:0] addr, input logic [15:0] data);
        bus_wr    <= 1'b1;
        bus_addr  <= addr;
        bus_wdata <= data;
        @(posedge mclk);
        bus_wr <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic bus_read(input logic [4:0] addr, input logic [15:0] expected);
        exp_q.push_back(expected);
        bus_rd   <= 1'b1;
        bus_addr <= addr;
        @(posedge mclk);
        bus_rd <= 1'b0;
        @(posedge mclk);
    endtask

    // flag lands one edge after the pulse, outputs one edge later
    task automatic fire_event(input int idx);
        fire     <= 1'b1;
        fire_idx <= 5'(idx);
        @(posedge mclk);
        fire <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask

    task automatic check_req(input int level, input int src);
        @(negedge mclk);
        check({15'h0, irq}, {15'h0, level != 0});
        check(16'(req_level), 16'(level));
        check(16'(req_source), 16'(src));
        @(posedge mclk);
    endtask

    always @(posedge mclk)
        rd_pending <= bus_rd;
    always @(negedge mclk)
        if (rd_pending === 1'b1)
            check(bus_rdata, exp_q.pop_front());

    initial
    begin
        logic [15:0] data;
        mclk = 1'b0;
        reset_n = 1'b0;
        clk_en = 1'b1;
        bus_addr = '0;
        bus_wdata = '0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        fire = 1'b0;
        fire_idx = '0;
        failures = 0;
        comparisons = 0;
        repeat (20) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        void'($urandom(61));
        for (int i = 0; i < 8; i++)
            bus_read(IPEB_OFS_PRIO_ZERO + 5'(i), IPEB_PRIO_RESET[i]);
        bus_read(IPEB_OFS_SERIAL_ERR_EN, 16'h0000);
        for (int i = 0; i < 8; i++)
        begin
            data = 16'($urandom);
            bus_write(IPEB_OFS_PRIO_ZERO + 5'(i), data);
            bus_read(IPEB_OFS_PRIO_ZERO + 5'(i), data & IPEB_PRIO_MASK[i]);
        end
        data = 16'($urandom);
        bus_write(IPEB_OFS_SERIAL_ERR_EN, data);
        bus_read(IPEB_OFS_SERIAL_ERR_EN, data & IPEB_SERIAL_ERR_BIT);
        for (int i = 0; i < 15; i++)
            bus_read(5'h11 + 5'(i), 16'h0000);
        bus_write(IPEB_OFS_SERIAL_ERR_EN, 16'h0000);
        bus_write(IPEB_OFS_ENABLE_ZERO, 16'h0008);
        for (int code = 0; code < 8; code++)
        begin
            bus_write(IPEB_OFS_PRIO_ZERO, 16'(code) << 12);
            fire_event(3);
            check_req(code, (code != 0) ? 3 : 0);
            bus_read(IPEB_OFS_FLAG_ZERO, 16'h0008);
            bus_write(IPEB_OFS_FLAG_ZERO, 16'h0008);
        end
        bus_write(IPEB_OFS_PRIO_SIXTEEN, 16'h0070);
        bus_write(IPEB_OFS_SERIAL_ERR_EN, 16'h0002);
        fire_event(20);
        check_req(7, 20);
        bus_read(IPEB_OFS_FLAG_FOUR, 16'h0002);
        bus_write(IPEB_OFS_PRIO_ZERO, 16'h7000);
        fire_event(3);
        check_req(7, 3);
        bus_read(IPEB_OFS_REQ_LOW, 16'h0008);
        bus_read(IPEB_OFS_REQ_HIGH, 16'h0010);
        bus_read(IPEB_OFS_ARB_STATUS, 16'h0703);
        bus_write(IPEB_OFS_PRIO_ZERO, 16'h6000);
        check_req(7, 20);
        bus_write(IPEB_OFS_SERIAL_ERR_EN, 16'h0000);
        check_req(6, 3);
        // a write while the enable is low must not land
        clk_en <= 1'b0;
        bus_write(IPEB_OFS_SERIAL_ERR_EN, 16'h0002);
        clk_en <= 1'b1;
        bus_read(IPEB_OFS_SERIAL_ERR_EN, 16'h0000);
        check_req(6, 3);
        finish_test();
    end

    initial
    begin
        repeat (6000) @(posedge mclk);
        failures++;
        finish_test();
    end
endmodule

bind ipeb_bank ipeb_checker ipeb_checker_inst (.mclk(mclk), .reset_n(reset_n),
    .clk_en(clk_en), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .src_event(src_event), .bus_rdata(bus_rdata), .src_req(src_req),
    .req_level(req_level), .req_source(req_source), .irq(irq));
